// *** logic/pss_int_arb.sv ***
// Fixed-priority pick among enabled pending interrupt requests.
// Assumes bit 0 carries the lowest vector address.
`include "pss_cfg.svh"

module pss_int_arb
    import pss_pkg::*;
(
    // Requests
    input  logic [`PSS_NSRC-1:0]   req,
    // Grant
    output logic                   grant_valid,
    output logic [`PSS_SRC_W-1:0]  grant_id
);

    // ----------------------------------------------------------------
    // Lowest index wins
    // ----------------------------------------------------------------
    always_comb begin
        grant_valid = 1'b0;
        grant_id    = '0;
        for (int i = `PSS_NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                grant_valid = 1'b1;
                grant_id    = i[`PSS_SRC_W-1:0];
            end
        end
    end

endmodule

// *** logic/pss_stack.sv ***
// Eight-entry return stack with its hidden index.
// Assumes push and pop never arrive in the same cycle.
`include "pss_cfg.svh"

module pss_stack
    import pss_pkg::*;
(
    // Clock and reset
    input  logic                   clk,
    input  logic                   rst_n,
    input  logic                   clk_en,
    // Stack control
    input  logic                   push,
    input  logic                   pop,
    input  pss_addr_t              push_data,
    // Stack view
    output pss_addr_t              top_data,
    output logic [`PSS_IDX_W-1:0]  return_stack_index
);

    pss_addr_t                     entry_mem [`PSS_STACK_DEPTH];
    logic      [`PSS_IDX_W-1:0]    idx_q;

    // ----------------------------------------------------------------
    // Storage, no software path
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            entry_mem[idx_q] <= push_data;
        end
    end

    // ----------------------------------------------------------------
    // Index, wraps on overflow
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= '0;
        end else if (clk_en) begin
            if (push) begin
                idx_q <= idx_q + 3'h1;
            end else if (pop) begin
                idx_q <= idx_q - 3'h1;
            end
        end
    end

    assign top_data           = entry_mem[idx_q - 3'h1];
    assign return_stack_index = idx_q;

endmodule

// *** logic/pss_top.sv ***
// Next-address logic: counter, return stack, vectors, skips, jumps.
// Assumes decoder ops and interrupt events are synchronous to clk.
`include "pss_cfg.svh"

module pss_top
    import pss_pkg::*;
#(
    parameter bit WIDE_ROM = 1'b1
)
(
    // Clock and reset
    input  logic                   clk,
    input  logic                   rst_n,
    input  logic                   clk_en,
    // Decoder ops
    input  logic                   op_valid,
    input  pss_op_t                op_kind,
    input  logic [`PSS_LOW_W-1:0]  op_addr,
    input  logic [7:0]             counter_low_byte,
    input  logic                   bank_select_top_bit,
    // Interrupt sources
    input  logic                   ext_int_n,
    input  logic                   tmr0_ovf,
    input  logic                   tmr1_ovf,
    input  logic                   periph_irq,
    input  logic                   rtc_irq,
    input  logic                   mf_irq,
    input  logic [`PSS_NSRC-1:0]   int_en,
    // Program memory and status
    output pss_addr_t              pm_addr,
    output logic                   fetch_discard_q,
    output logic                   int_ack_q,
    output logic [`PSS_SRC_W-1:0]  int_src_q,
    output logic [`PSS_NSRC-1:0]   int_pending,
    output logic                   stack_full,
    output logic                   stack_overflow_q
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    pss_addr_t                     pc_q;
    pss_addr_t                     pc_d;
    pss_addr_t                     top_data;
    pss_addr_t                     rom_mask;
    logic [`PSS_CNT_W-1:0]         count_q;
    logic [`PSS_NSRC-1:0]          pend_q;
    logic [`PSS_NSRC-1:0]          events;
    logic [`PSS_NSRC-1:0]          ack_clr;
    logic [`PSS_SRC_W-1:0]         grant_id;
    logic [`PSS_IDX_W-1:0]         stack_idx;
    logic                          grant_valid;
    logic                          ext_q;
    logic                          full;
    logic                          slot_free;
    logic                          accept;
    logic                          do_call;
    logic                          do_pop;
    logic                          do_push;
    logic                          branch;
    logic                          bank_bit;

    // ----------------------------------------------------------------
    // Vector lookup
    // ----------------------------------------------------------------
    function automatic pss_addr_t vec_of(logic [`PSS_SRC_W-1:0] id);
        pss_addr_t v;
        v = `PSS_VEC_RESET;
        unique case (id)
            3'h0: v = `PSS_VEC_EXT;
            3'h1: v = `PSS_VEC_TMR0;
            3'h2: v = `PSS_VEC_TMR1;
            3'h3: v = `PSS_VEC_PERIPH;
            3'h4: v = `PSS_VEC_RTC;
            3'h5: v = `PSS_VEC_MF;
            default: v = `PSS_VEC_RESET;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Request capture
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_q <= 1'b1;
        end else if (clk_en) begin
            ext_q <= ext_int_n;
        end
    end

    assign events = {mf_irq, rtc_irq, periph_irq,
                     tmr1_ovf, tmr0_ovf, ext_q & ~ext_int_n};

    // Flag stays set while the stack is full; a new event beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
        end else if (clk_en) begin
            pend_q <= (pend_q & ~ack_clr) | events;
        end
    end

    pss_int_arb u_arb (
        .req         (pend_q & int_en),
        .grant_valid (grant_valid),
        .grant_id    (grant_id)
    );

    // ----------------------------------------------------------------
    // Op decode and acceptance
    // ----------------------------------------------------------------
    assign full      = (count_q == `PSS_CNT_FULL);
    assign slot_free = !op_valid || (op_kind == OP_NEXT);
    assign accept    = grant_valid && !full && slot_free;
    assign ack_clr   = accept ? (`PSS_NSRC'(1) << grant_id) : '0;
    assign do_call   = op_valid && (op_kind == OP_CALL);
    assign do_pop    = op_valid && ((op_kind == OP_RET) ||
                                    (op_kind == OP_INTERRUPT_RETURN_OP));
    assign do_push   = accept || do_call;
    assign branch    = accept || (op_valid && (op_kind != OP_NEXT));
    assign rom_mask  = WIDE_ROM ? `PSS_MASK_16K : `PSS_MASK_8K;
    assign bank_bit  = WIDE_ROM ? bank_select_top_bit : 1'b0;

    pss_stack u_stack (
        .clk                (clk),
        .rst_n              (rst_n),
        .clk_en             (clk_en),
        .push               (do_push),
        .pop                (do_pop),
        .push_data          (pc_q),
        .top_data           (top_data),
        .return_stack_index (stack_idx)
    );

    // ----------------------------------------------------------------
    // Next counter value
    // ----------------------------------------------------------------
    always_comb begin
        pc_d = {pc_q[`PSS_PC_W-1],
                pc_q[`PSS_LOW_W-1:0] + `PSS_STEP_SEQ};
        if (accept) begin
            pc_d = vec_of(grant_id);
        end else if (op_valid) begin
            unique case (op_kind)
                OP_NEXT: begin
                    pc_d = {pc_q[`PSS_PC_W-1],
                            pc_q[`PSS_LOW_W-1:0] + `PSS_STEP_SEQ};
                end
                OP_JUMP, OP_CALL: begin
                    pc_d = {bank_bit, op_addr};
                end
                OP_RET, OP_INTERRUPT_RETURN_OP: begin
                    pc_d = top_data;
                end
                OP_PCL_WR: begin
                    pc_d = {pc_q[`PSS_PC_W-1:8], counter_low_byte};
                end
                OP_SKIP: begin
                    pc_d = {pc_q[`PSS_PC_W-1],
                            pc_q[`PSS_LOW_W-1:0] + `PSS_STEP_SKIP};
                end
                default: begin
                    pc_d = pc_q;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= `PSS_VEC_RESET;
        end else if (clk_en) begin
            pc_q <= pc_d & rom_mask;
        end
    end

    // ----------------------------------------------------------------
    // Stack occupancy
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (clk_en) begin
            if (do_push && !full) begin
                count_q <= count_q + 4'h1;
            end else if (do_pop && (count_q != '0)) begin
                count_q <= count_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_overflow_q <= 1'b0;
        end else if (clk_en && do_call && full) begin
            stack_overflow_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Acknowledge and discard marks
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_ack_q       <= 1'b0;
            int_src_q       <= '0;
            fetch_discard_q <= 1'b0;
        end else if (clk_en) begin
            int_ack_q       <= accept;
            int_src_q       <= accept ? grant_id : int_src_q;
            fetch_discard_q <= branch;
        end
    end

    assign pm_addr     = pc_q;
    assign int_pending = pend_q;
    assign stack_full  = count_q[`PSS_CNT_W-1];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    reset_start_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |-> (pc_q == `PSS_VEC_RESET) && (count_q == '0))
        else $error("counter or stack not cleared by reset");

    reset_index_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |-> stack_idx == '0)
        else $error("stack index not at top after reset");

    ext_vector_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        int_ack_q && int_src_q == 3'h0 |-> pc_q == `PSS_VEC_EXT)
        else $error("external interrupt vector wrong");

    tmr0_vector_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        int_ack_q && int_src_q == 3'h1 |-> pc_q == `PSS_VEC_TMR0)
        else $error("first timer vector wrong");

    tmr1_vector_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        int_ack_q && int_src_q == 3'h2 |-> pc_q == `PSS_VEC_TMR1)
        else $error("second timer vector wrong");

    periph_vector_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        int_ack_q && int_src_q == 3'h3 |-> pc_q == `PSS_VEC_PERIPH)
        else $error("peripheral vector wrong");

    rtc_vector_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        int_ack_q && int_src_q == 3'h4 |-> pc_q == `PSS_VEC_RTC)
        else $error("clock time-out vector wrong");

    mf_vector_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        int_ack_q && int_src_q == 3'h5 |-> pc_q == `PSS_VEC_MF)
        else $error("multi-function vector wrong");

    full_hold_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && full && |(pend_q & int_en)
        |=> !int_ack_q &&
            (pend_q & $past(pend_q & int_en)) == $past(pend_q & int_en))
        else $error("interrupt taken with full stack");

    push_depth_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && do_push && !full
        |=> count_q == $past(count_q) + 4'h1)
        else $error("push did not deepen the stack");

    ret_restore_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && !accept && do_push ##1 clk_en && do_pop
        |=> pc_q == ($past(pc_q, 2) & rom_mask))
        else $error("return did not restore pushed counter");

    low_write_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && !accept && op_valid && op_kind == OP_PCL_WR
        |=> pc_q == {$past(pc_q[13:8]), $past(counter_low_byte)})
        else $error("low byte write corrupted upper counter");

    jump_load_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && op_valid && op_kind == OP_JUMP
        |=> pc_q == ({$past(bank_bit), $past(op_addr)} & rom_mask))
        else $error("jump target wrong");

    narrow_rom_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !WIDE_ROM |-> pc_q[13] == 1'b0)
        else $error("counter bit 13 set in 8K variant");

    skip_step_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && !accept && op_valid && op_kind == OP_SKIP
        |=> pc_q[13] == $past(pc_q[13]) &&
            pc_q[12:0] == $past(pc_q[12:0]) + 13'h2)
        else $error("skip did not advance by two in bank");

    lowest_first_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && accept && pend_q[0] && int_en[0]
        |=> int_ack_q && int_src_q == 3'h0)
        else $error("lowest vector not served first");

    call_full_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && do_call && full |=> stack_overflow_q && full)
        else $error("call on full stack not flagged");

    lowest_win_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && accept
        |-> (pend_q & int_en & ((`PSS_NSRC'(1) << grant_id) - `PSS_NSRC'(1)))
            == '0)
        else $error("a lower vector was passed over");

    ack_push_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && accept
        |=> stack_idx == $past(stack_idx) + 3'h1 && int_ack_q)
        else $error("acknowledge did not push the counter");

    pop_release_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && full && do_pop ##1 clk_en && slot_free && grant_valid
        |=> int_ack_q)
        else $error("held request not served after a return");

    pop_index_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        clk_en && do_pop
        |=> stack_idx == $past(stack_idx) - 3'h1)
        else $error("return did not step the index back");

endmodule

// *** shared/pss_cfg.svh ***
// Constants of the program sequencer with its return stack.
// Assumes inclusion by the sequencer package and modules only.
//
// Function
// - Eight-entry stack holds counter values only; software cannot reach it.
// - Stack index selects the active entry; software cannot see or change it.
// - Call or interrupt acknowledge pushes the current counter.
// - Either return loads the full counter from the top entry, popping it.
// - Reset points the stack index at the empty top position.
// - Full stack: request flag kept, acknowledge and vectoring withheld.
// - A return that frees a level lets the held request be serviced.
// - Call on a full stack still executes and overflows.
// - Reset clears the counter; fetching starts at address zero.
// - External interrupt pin going low vectors to 0x004.
// - First timer overflow vectors to 0x008.
// - Second timer overflow vectors to 0x00C.
// - Low byte write keeps counter bits 13..8, takes bits 7..0 written.
// - Jump and call take bits 12..0 from instruction, bit 13 from bank.
// - In the 8K variant the bank bit feeding counter bit 13 is zero.
// - Counter addresses 8K or 16K words with 13 or 14 bits.
// - Tone receiver and modem decoder interrupt vectors to 0x010.
// - Real-time clock time-out vectors to 0x014.
// - Multi-function interrupt vectors to 0x018.
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// ----------------------------------------------------------------
// Counter and stack geometry
// ----------------------------------------------------------------
`define PSS_PC_W        14
`define PSS_LOW_W       13
`define PSS_STACK_DEPTH 8
`define PSS_IDX_W       3
`define PSS_CNT_W       4
`define PSS_CNT_FULL    4'h8
`define PSS_NSRC        6
`define PSS_SRC_W       3

// ----------------------------------------------------------------
// Vectors and counter steps
// ----------------------------------------------------------------
`define PSS_VEC_RESET   14'h0000
`define PSS_VEC_EXT     14'h0004
`define PSS_VEC_TMR0    14'h0008
`define PSS_VEC_TMR1    14'h000C
`define PSS_VEC_PERIPH  14'h0010
`define PSS_VEC_RTC     14'h0014
`define PSS_VEC_MF      14'h0018
`define PSS_MASK_16K    14'h3FFF
`define PSS_MASK_8K     14'h1FFF
`define PSS_STEP_SEQ    13'h0001
`define PSS_STEP_SKIP   13'h0002

`endif

// *** shared/pss_pkg.sv ***
// Types of the program sequencer with its return stack.
// Assumes pss_cfg.svh is on the include path.
`include "pss_cfg.svh"

package pss_pkg;

    typedef logic [`PSS_PC_W-1:0] pss_addr_t;

    typedef enum logic [2:0] {
        OP_NEXT,
        OP_JUMP,
        OP_CALL,
        OP_RET,
        OP_INTERRUPT_RETURN_OP,
        OP_PCL_WR,
        OP_SKIP
    } pss_op_t;

endpackage

// *** verification/pss_src_model.sv ***
// Interrupt sources standing in front of the sequencer.
// Assumes fire requests are driven on the rising edge of clk.
module pss_src_model (
    // Clock
    input  wire logic       clk,
    // Requests from the bench
    input  wire logic [5:0] fire,
    // Source lines
    output logic            ext_int_n,
    output logic            tmr0_ovf,
    output logic            tmr1_ovf,
    output logic            periph_irq,
    output logic            rtc_irq,
    output logic            mf_irq
);
    timeunit 1ns;
    timeprecision 1ps;

    int hold_q;

    initial begin
        ext_int_n  = 1'b1;
        {mf_irq, rtc_irq, periph_irq, tmr1_ovf, tmr0_ovf} = 5'h00;
        hold_q     = 0;
    end

    // ----------------------------------------------------------------
    // Pin held low three cycles, pulses one cycle
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        hold_q    <= fire[0] ? 2 : (hold_q > 0 ? hold_q - 1 : 0);
        ext_int_n <= !(fire[0] || hold_q > 0);
        {mf_irq, rtc_irq, periph_irq, tmr1_ovf, tmr0_ovf} <= fire[5:1];
    end
endmodule

// *** verification/tb.sv ***
// Bench of the program sequencer against a cycle model.
// Assumes idle slots are OP_NEXT, sometimes shown with op_valid low.
module tb;
    import pss_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic op_valid = 1'b1;
    pss_addr_t narrow_addr;
    pss_op_t op_kind = OP_NEXT;
    logic [12:0] op_addr = 13'h0000;
    logic [7:0] counter_low_byte = 8'h00;
    logic bank_select_top_bit = 1'b0;
    logic [5:0] int_en = 6'h00;
    logic [5:0] fire = 6'h00;
    logic ext_int_n, tmr0_ovf, tmr1_ovf, periph_irq, rtc_irq, mf_irq;
    pss_addr_t pm_addr;
    logic fetch_discard_q, int_ack_q, stack_full, stack_overflow_q;
    logic [2:0] int_src_q;
    logic [5:0] int_pending;
    int miscompares = 0;
    int total_checks = 0;
    int pc, idx, cnt, src, r;
    int stk [8];
    bit [5:0] pend;
    bit ack, ovf, disc, ext_prev;

    always #4 clk = ~clk;

    pss_top pss_top_inst (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .op_valid(op_valid),
        .op_kind(op_kind), .op_addr(op_addr),
        .counter_low_byte(counter_low_byte),
        .bank_select_top_bit(bank_select_top_bit),
        .ext_int_n(ext_int_n), .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf),
        .periph_irq(periph_irq), .rtc_irq(rtc_irq), .mf_irq(mf_irq),
        .int_en(int_en), .pm_addr(pm_addr),
        .fetch_discard_q(fetch_discard_q), .int_ack_q(int_ack_q),
        .int_src_q(int_src_q), .int_pending(int_pending),
        .stack_full(stack_full), .stack_overflow_q(stack_overflow_q)
    );

    pss_src_model pss_src_model_inst (
        .clk(clk), .fire(fire), .ext_int_n(ext_int_n),
        .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf), .periph_irq(periph_irq),
        .rtc_irq(rtc_irq), .mf_irq(mf_irq)
    );

    // Narrow variant on the same stimulus
    if (1'b1) begin : narrow
        pss_top #(.WIDE_ROM(1'b0)) pss_top_inst (
            .clk(clk), .rst_n(rst_n), .clk_en(clk_en),
            .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
            .counter_low_byte(counter_low_byte),
            .bank_select_top_bit(bank_select_top_bit),
            .ext_int_n(ext_int_n), .tmr0_ovf(tmr0_ovf),
            .tmr1_ovf(tmr1_ovf), .periph_irq(periph_irq),
            .rtc_irq(rtc_irq), .mf_irq(mf_irq), .int_en(int_en),
            .pm_addr(narrow_addr), .fetch_discard_q(),
            .int_ack_q(), .int_src_q(), .int_pending(), .stack_full(),
            .stack_overflow_q()
        );
    end

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic void push(int v);
        stk[idx] = v;
        idx = (idx + 1) % 8;
        if (cnt < 8) cnt++;
    endfunction

    always @(posedge clk or negedge rst_n) begin : ref_model
        int i, win;
        bit [5:0] ev;
        pss_op_t kind;
        if (!rst_n) begin
            {pc, idx, cnt, src} = 0;
            {pend, ack, ovf, disc, ext_prev} = 10'h001;
        end else if (clk_en) begin
            kind = op_valid ? op_kind : OP_NEXT;
            ev = {mf_irq, rtc_irq, periph_irq, tmr1_ovf, tmr0_ovf,
                  ext_prev & !ext_int_n};
            ext_prev = ext_int_n;
            win = -1;
            if (kind == OP_NEXT && cnt < 8)
                for (i = 5; i >= 0; i--)
                    if (pend[i] && int_en[i]) win = i;
            ack = (win >= 0);
            disc = 1'b1;
            if (ack) begin
                push(pc);
                pend[win] = 1'b0;
                src = win;
                pc = 4 * (win + 1);
            end else case (kind)
                OP_NEXT: begin
                    pc = (pc & 'h2000) | ((pc + 1) & 'h1FFF);
                    disc = 1'b0;
                end
                OP_JUMP: pc = bank_select_top_bit * 'h2000 + op_addr;
                OP_CALL: begin
                    if (cnt == 8) ovf = 1'b1;
                    push(pc);
                    pc = bank_select_top_bit * 'h2000 + op_addr;
                end
                OP_PCL_WR: pc = (pc & 'h3F00) | counter_low_byte;
                OP_SKIP: pc = (pc & 'h2000) | ((pc + 2) & 'h1FFF);
                default: begin
                    idx = (idx + 7) % 8;
                    pc = stk[idx];
                    if (cnt > 0) cnt--;
                end
            endcase
            pend |= ev;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(negedge clk) begin
        check(pm_addr, pc[13:0]);
        check(narrow_addr, pc[12:0]);
        check(int_ack_q, ack);
        check(int_src_q, src[2:0]);
        check(int_pending, pend);
        check(stack_full, cnt == 8);
        check(stack_overflow_q, ovf);
        check(fetch_discard_q, disc);
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    task automatic op(pss_op_t k, int a = 0, int b = 0, int f = 0,
                      int bk = 0, int ce = 1);
        bit idle;
        idle = (k == OP_NEXT) && ($urandom % 2 == 1);
        @(posedge clk);
        op_valid <= !idle;
        op_kind <= idle ? pss_op_t'(1 + $urandom % 6) : k;
        op_addr <= a[12:0];
        counter_low_byte <= b[7:0];
        fire <= f[5:0];
        bank_select_top_bit <= bk[0];
        clk_en <= ce[0];
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h28c05579));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        int_en <= 6'h3F;
        repeat (3) op(OP_NEXT);
        for (int i = 0; i < 6; i++) begin
            op(OP_NEXT, 0, 0, 1 << i);
            repeat (5) op(OP_NEXT);
            op(OP_INTERRUPT_RETURN_OP);
        end
        op(OP_NEXT, 0, 0, 6'h3F);
        repeat (10) op(OP_NEXT);
        repeat (6) op(OP_RET);
        op(OP_JUMP, 13'h1FFF, 0, 0, 1);
        op(OP_SKIP);
        op(OP_PCL_WR, 0, 8'hA5);
        repeat (8) op(OP_CALL, $urandom, 0, 0, $urandom);
        op(OP_NEXT, 0, 0, 6'h02);
        repeat (3) op(OP_NEXT);
        op(OP_CALL, 13'h0ABC);
        op(OP_RET);
        repeat (3) op(OP_NEXT);
        rst_n <= 1'b0;
        repeat (2) op(OP_NEXT);
        rst_n <= 1'b1;
        for (int n = 0; n < 3000; n++) begin
            if (n % 64 == 0) int_en <= 6'($urandom);
            r = $urandom % 16;
            if (r < 7 || (r >= 10 && r <= 12 && cnt < 2))
                op(OP_NEXT, 0, 0, ($urandom % 4 == 0) ? $urandom : 0,
                   0, ($urandom % 10) != 0);
            else
                op(r == 7 ? OP_JUMP : r < 10 || r == 15 ? OP_CALL :
                   r < 12 ? OP_RET : r == 12 ? OP_INTERRUPT_RETURN_OP :
                   r == 13 ? OP_PCL_WR : OP_SKIP,
                   $urandom, $urandom, 0, $urandom,
                   ($urandom % 10) != 0);
        end
        repeat (2) op(OP_NEXT);
        tally_and_finish();
    end
endmodule
